// file: hw/wdt_pkg.sv
// constants, field layout and bus carriers for the supervisory block
// assumes a single 200 MHz core clock that stands in for the oscillator
//
// Functional notes
// - watchdog is a free-running divider chain with selectable output
// - expiry with watchdog enabled raises a system reset
// - any reset disables the watchdog and clears its counters
// - run-enable set starts counting; cleared stops counting and holds the count
// - restart bit clears 14-bit counter, prescaler and itself at next machine cycle
// - watchdog counts in idle only when idle-run bit is set
// - three-bit code selects prescale 2 to 256, doubling per code
// - period is 2^14 times prescale times 12 oscillator periods
// - at 20 MHz period spans 19.66 ms to 2.52 s
// - input clock is halved before internal use
// - doze request stops processor clock, peripherals keep running
// - idle ends on interrupt request or reset
// - deep sleep request stops every clock including oscillator
// - deep sleep ignores interrupts, only reset ends it
// - cold start flag set at power-on, cleared by software only
// - two user flags just store software writes
// - reset input sampled at state5_phase2, needs two machine cycles
// - reset input is deglitched
// - reset loads ports FFH, stack 07H, others 00H, keeps bit 4

package wdt_pkg;

  // ==================================================================
  // timing
  localparam int unsigned CORE_CLK_HZ     = 200_000_000;
  localparam int unsigned OSC_PER_MACHINE = 12;
  localparam int unsigned RST_MIN_MACHINE = 2;
  localparam int unsigned WDT_COUNT_BITS  = 14;
  localparam int unsigned REF_OSC_HZ      = 20_000_000;
  localparam int unsigned WDT_MIN_US      = 19_660;
  localparam int unsigned WDT_MAX_MS      = 2_500;
  localparam longint WDT_MIN_CYCLES =
    longint'(WDT_MIN_US) * longint'(REF_OSC_HZ) / 1_000_000;
  localparam logic [3:0] OSC_LAST           = 4'hb;
  localparam logic [3:0] SAMPLE_PHASE_COUNT = 4'h9;

  // ==================================================================
  // register map: index, byte address is four times it
  localparam logic [9:0] PWRCTL_INDEX = 10'h087;
  localparam logic [9:0] WDCTL_INDEX  = 10'h08f;
  localparam logic [9:0] STAT_INDEX   = 10'h090;

  localparam int unsigned PC_DOZE = 0;
  localparam int unsigned PC_DEEP = 1;
  localparam int unsigned PC_UFLO = 2;
  localparam int unsigned PC_UFHI = 3;
  localparam int unsigned PC_COLD = 4;

  localparam int unsigned WD_RUN  = 7;
  localparam int unsigned WD_RST  = 6;
  localparam int unsigned WD_IDLE = 5;

  localparam logic [7:0] SFR_RESET   = 8'h00;
  localparam logic [7:0] PORT_RESET  = 8'hff;
  localparam logic [7:0] STACK_RESET = 8'h07;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_DOWN} power_mode_e;

  // ==================================================================
  // bus carriers
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_s;

endpackage

// file: hw/reset_filter.sv
// deglitch and machine-cycle sampling of the external reset level
// assumes sampleTick pulses once per machine cycle
`timescale 1ns/1ps

module reset_filter #(
  parameter int unsigned SAMPLES = 2
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic sampleTick,
  input  wire logic rawReset,
  output logic      resetSeen
);

  logic               prevRaw_q;
  logic [SAMPLES-1:0] hist_q;
  logic [SAMPLES-1:0] histNext;
  logic               steadyHigh;

  // ==================================================================
  // filtering
  // a level must hold two clocks before it counts
  assign steadyHigh = rawReset & prevRaw_q;
  assign histNext   = sampleTick ?
                      {hist_q[SAMPLES-2:0], steadyHigh} : hist_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prevRaw_q <= 1'b0;
      hist_q    <= '0;
      resetSeen <= 1'b0;
    end else begin
      prevRaw_q <= rawReset;
      hist_q    <= histNext;
      resetSeen <= &histNext;
    end
  end

  // ==================================================================
  // checks
  a_low_sample_drops : assert property (@(posedge core_clk) disable iff (srst)
    (sampleTick && !steadyHigh) |=> !resetSeen)
    else $error("reset seen despite a low sample");

  a_glitch_ignored : assert property (@(posedge core_clk) disable iff (srst)
    (!prevRaw_q && !resetSeen) |=> !resetSeen)
    else $error("one-clock reset pulse was taken");

endmodule // reset_filter

// file: hw/watchdog_power_reset_ctrl.sv
// watchdog, power modes and reset supervision with an AXI4-Lite slave
// assumes core_clk is the oscillator and srst is the power-on reset
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

module watchdog_power_reset_ctrl #(
  parameter int unsigned WDT_BITS = wdt_pkg::WDT_COUNT_BITS,
  parameter int unsigned RST_SAMPLES = wdt_pkg::RST_MIN_MACHINE
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire wdt_pkg::axil_req_s axiReq,
  output wdt_pkg::axil_rsp_s     axiRsp,
  input  wire logic              extReset,
  input  wire logic              irqReq,
  output logic                   sysReset_q,
  output logic                   cpuClkRun_q,
  output logic                   periphClkRun_q,
  output logic                   oscRun_q,
  output logic [7:0]             portInit_q,
  output logic [7:0]             stackInit_q
);

  // ==================================================================
  // declarations
  logic [3:0]          oscCnt_q;
  logic                oscLive;
  logic                machineTick;
  logic                samplePhaseTick;
  logic                extSeen;
  logic                intReset;

  wdt_pkg::power_mode_e powerMode_q;
  wdt_pkg::power_mode_e powerMode_d;
  logic                 uflag_q [2];
  logic                 coldStart_q;
  logic                 runEn_q;
  logic                 restart_q;
  logic                 idleRun_q;
  logic [2:0]           psCode_q;

  logic [7:0]          presc_q;
  logic [WDT_BITS-1:0] wdCnt_q;
  logic [7:0]          presMax;
  logic                presHit;
  logic                wdCounting;
  logic                wdFire;
  logic                restartDue;

  logic                awHeld_q;
  logic                wHeld_q;
  logic [9:0]          awIdx_q;
  logic [7:0]          wByte_q;
  logic                wLane_q;
  logic                awReady_q;
  logic                wReady_q;
  logic                bValid_q;
  logic [1:0]          bResp_q;
  logic                arReady_q;
  logic                rValid_q;
  logic [31:0]         rData_q;
  logic [1:0]          rResp_q;

  logic                awHs;
  logic                wHs;
  logic                arHs;
  logic                awHeldNext;
  logic                wHeldNext;
  logic                rValidNext;
  logic                doWrite;
  logic                wrHit;
  logic                wrPwrCtl;
  logic                wrWdCtl;
  logic                wrMapped;
  logic [9:0]          arIdx;
  logic                rdMapped;
  logic [7:0]          pwrCtlView;
  logic [7:0]          wdCtlView;
  logic [31:0]         statView;
  logic [31:0]         rdMux;

  // ==================================================================
  // oscillator divider: halved clock gives states and phases
  assign oscLive     = (powerMode_q != wdt_pkg::PM_DOWN) | extReset;
  assign machineTick = oscLive & (oscCnt_q == wdt_pkg::OSC_LAST);
  // state index is oscCnt_q[3:1], phase is oscCnt_q[0]
  assign samplePhaseTick = oscLive & (oscCnt_q == wdt_pkg::SAMPLE_PHASE_COUNT);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      oscCnt_q <= 4'h0;
    end else if (machineTick) begin
      oscCnt_q <= 4'h0;
    end else if (oscLive) begin
      oscCnt_q <= oscCnt_q + 4'h1;
    end
  end

  // ==================================================================
  // external reset and watchdog reset
  reset_filter #(
    .SAMPLES (RST_SAMPLES)
  ) u_reset_filter (
    .core_clk   (core_clk),
    .srst       (srst),
    .sampleTick (samplePhaseTick),
    .rawReset   (extReset),
    .resetSeen  (extSeen)
  );

  assign intReset = srst | sysReset_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sysReset_q <= 1'b0;
    end else begin
      // a watchdog reset lasts to the next machine cycle edge
      sysReset_q <= extSeen | wdFire |
                    (sysReset_q & ~machineTick);
    end
  end

  // ==================================================================
  // watchdog divider chain
  assign presMax    = 8'((9'h002 << psCode_q) - 9'h001);
  assign presHit    = (presc_q == presMax);
  assign wdCounting = runEn_q & machineTick &
                      (powerMode_q != wdt_pkg::PM_DOWN) &
                      ~((powerMode_q == wdt_pkg::PM_IDLE) & ~idleRun_q);
  assign wdFire     = wdCounting & presHit & (&wdCnt_q);
  assign restartDue = restart_q & machineTick;

  always_ff @(posedge core_clk) begin
    if (intReset) begin
      presc_q <= 8'h00;
      wdCnt_q <= '0;
    end else if (restartDue) begin
      presc_q <= 8'h00;
      wdCnt_q <= '0;
    end else if (wdCounting) begin
      presc_q <= presHit ? 8'h00 : presc_q + 8'h01;
      if (presHit) begin
        wdCnt_q <= wdCnt_q + 1'b1;
      end
    end
  end

  // ==================================================================
  // power modes
  always_comb begin
    powerMode_d = powerMode_q;
    case (powerMode_q)
      wdt_pkg::PM_RUN: begin
        if (wrPwrCtl && wByte_q[wdt_pkg::PC_DEEP]) begin
          powerMode_d = wdt_pkg::PM_DOWN;
        end else if (wrPwrCtl && wByte_q[wdt_pkg::PC_DOZE]) begin
          powerMode_d = wdt_pkg::PM_IDLE;
        end
      end
      wdt_pkg::PM_IDLE: begin
        if (wrPwrCtl && wByte_q[wdt_pkg::PC_DEEP]) begin
          powerMode_d = wdt_pkg::PM_DOWN;
        end else if (irqReq) begin
          powerMode_d = wdt_pkg::PM_RUN;
        end
      end
      wdt_pkg::PM_DOWN: begin
        powerMode_d = wdt_pkg::PM_DOWN;
      end
      default: begin
        powerMode_d = wdt_pkg::PM_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (intReset) begin
      powerMode_q    <= wdt_pkg::PM_RUN;
      cpuClkRun_q    <= 1'b1;
      periphClkRun_q <= 1'b1;
      oscRun_q       <= 1'b1;
    end else begin
      powerMode_q    <= powerMode_d;
      cpuClkRun_q    <= (powerMode_d == wdt_pkg::PM_RUN);
      periphClkRun_q <= (powerMode_d != wdt_pkg::PM_DOWN);
      oscRun_q       <= (powerMode_d != wdt_pkg::PM_DOWN) | extReset;
    end
  end

  // ==================================================================
  // software registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      coldStart_q <= 1'b1;
    end else if (wrPwrCtl && !wByte_q[wdt_pkg::PC_COLD]) begin
      coldStart_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (intReset) begin
      uflag_q[0]  <= 1'b0;
      uflag_q[1]  <= 1'b0;
      runEn_q     <= 1'b0;
      idleRun_q   <= 1'b0;
      psCode_q    <= 3'h0;
      restart_q   <= 1'b0;
      portInit_q  <= wdt_pkg::PORT_RESET;
      stackInit_q <= wdt_pkg::STACK_RESET;
    end else begin
      if (wrPwrCtl) begin
        uflag_q[0] <= wByte_q[wdt_pkg::PC_UFLO];
        uflag_q[1] <= wByte_q[wdt_pkg::PC_UFHI];
      end
      if (wrWdCtl) begin
        runEn_q   <= wByte_q[wdt_pkg::WD_RUN];
        idleRun_q <= wByte_q[wdt_pkg::WD_IDLE];
        psCode_q  <= wByte_q[2:0];
      end
      // a new restart write wins over the self-clear
      if (wrWdCtl && wByte_q[wdt_pkg::WD_RST]) begin
        restart_q <= 1'b1;
      end else if (machineTick) begin
        restart_q <= 1'b0;
      end
    end
  end

  // ==================================================================
  // register views
  assign pwrCtlView = {3'h0, coldStart_q, uflag_q[1], uflag_q[0],
                     powerMode_q == wdt_pkg::PM_DOWN,
                     powerMode_q == wdt_pkg::PM_IDLE};
  assign wdCtlView = {runEn_q, restart_q, idleRun_q, 2'h0, psCode_q};
  assign statView = {16'(wdCnt_q), 8'(presc_q), 5'h00,
                     sysReset_q, extSeen, runEn_q};

  // ==================================================================
  // AXI4-Lite write path
  assign awHs       = axiReq.awvalid & awReady_q;
  assign wHs        = axiReq.wvalid & wReady_q;
  assign doWrite    = awHeld_q & wHeld_q & ~bValid_q;
  assign awHeldNext = (awHeld_q | awHs) & ~doWrite;
  assign wHeldNext  = (wHeld_q | wHs) & ~doWrite;
  assign wrMapped   = (awIdx_q == wdt_pkg::PWRCTL_INDEX) |
                      (awIdx_q == wdt_pkg::WDCTL_INDEX) |
                      (awIdx_q == wdt_pkg::STAT_INDEX);
  assign wrHit      = doWrite & wLane_q;
  assign wrPwrCtl   = wrHit & (awIdx_q == wdt_pkg::PWRCTL_INDEX);
  assign wrWdCtl    = wrHit & (awIdx_q == wdt_pkg::WDCTL_INDEX);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awIdx_q   <= 10'h000;
      wByte_q   <= 8'h00;
      wLane_q   <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q  <= 1'b0;
      bValid_q  <= 1'b0;
      bResp_q   <= wdt_pkg::RESP_OKAY;
    end else begin
      awHeld_q  <= awHeldNext;
      wHeld_q   <= wHeldNext;
      awReady_q <= ~awHeldNext;
      wReady_q  <= ~wHeldNext;
      if (awHs) begin
        awIdx_q <= axiReq.awaddr[11:2];
      end
      if (wHs) begin
        wByte_q <= axiReq.wdata[7:0];
        wLane_q <= axiReq.wstrb[0];
      end
      if (doWrite) begin
        bValid_q <= 1'b1;
        bResp_q  <= wrMapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_DECERR;
      end else if (axiReq.bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // ==================================================================
  // AXI4-Lite read path
  assign arHs       = axiReq.arvalid & arReady_q;
  assign rValidNext = arHs | (rValid_q & ~axiReq.rready);
  assign arIdx      = axiReq.araddr[11:2];
  assign rdMapped   = (arIdx == wdt_pkg::PWRCTL_INDEX) |
                      (arIdx == wdt_pkg::WDCTL_INDEX) |
                      (arIdx == wdt_pkg::STAT_INDEX);
  assign rdMux      = (arIdx == wdt_pkg::PWRCTL_INDEX) ? {24'h0, pwrCtlView} :
                      (arIdx == wdt_pkg::WDCTL_INDEX) ? {24'h0, wdCtlView} :
                      (arIdx == wdt_pkg::STAT_INDEX) ? statView : 32'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0;
      rResp_q   <= wdt_pkg::RESP_OKAY;
    end else begin
      arReady_q <= ~rValidNext;
      rValid_q  <= rValidNext;
      if (arHs) begin
        rData_q <= rdMux;
        rResp_q <= rdMapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_DECERR;
      end
    end
  end

  assign axiRsp = '{awready: awReady_q, wready: wReady_q,
                    bresp: bResp_q, bvalid: bValid_q,
                    arready: arReady_q, rdata: rData_q,
                    rresp: rResp_q, rvalid: rValid_q};

  // ==================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_restart_due;
    restart_q && machineTick && !wrWdCtl;
  endsequence

  a_fire_resets : assert property (wdFire |=> sysReset_q [*1] ##1 1'b1)
    else $error("watchdog expiry gave no reset");

  a_reset_clears : assert property (sysReset_q |=>
    (!runEn_q && wdCnt_q == '0 && presc_q == 8'h00))
    else $error("watchdog survived a reset");

  a_off_no_count : assert property ((!runEn_q && !sysReset_q && !restart_q)
    |=> $stable(wdCnt_q) && !wdFire)
    else $error("disabled watchdog moved");

  a_restart_done : assert property ((s_restart_due and !sysReset_q)
    |=> (wdCnt_q == '0 && presc_q == 8'h00 && !restart_q))
    else $error("restart did not clear the chain");

  a_restart_bound : assert property (restart_q |-> ##[0:12] !restart_q)
    else $error("restart bit stuck");

  a_idle_pause : assert property ((powerMode_q == wdt_pkg::PM_IDLE && !idleRun_q
    && !restart_q && !sysReset_q) |=> $stable(wdCnt_q))
    else $error("watchdog counted in idle");

  a_prescale_step : assert property ((wdCounting && !presHit && !restart_q
    && !sysReset_q) |=> $stable(wdCnt_q))
    else $error("counter stepped before prescale wrap");

  a_tick_spacing : assert property (machineTick && !extReset
    |=> !machineTick [*8] ##1 !machineTick [*3])
    else $error("machine cycle shorter than twelve clocks");

  a_idle_cpu_off : assert property (powerMode_q == wdt_pkg::PM_IDLE [*2]
    |-> !cpuClkRun_q && periphClkRun_q)
    else $error("idle left processor clock running");

  a_irq_wakes : assert property ((powerMode_q == wdt_pkg::PM_IDLE && irqReq
    && !wrPwrCtl) |=> powerMode_q == wdt_pkg::PM_RUN)
    else $error("interrupt did not end idle");

  a_down_sticks : assert property ((powerMode_q == wdt_pkg::PM_DOWN
    && !sysReset_q) |=> powerMode_q == wdt_pkg::PM_DOWN)
    else $error("deep sleep left without reset");

  a_down_osc_off : assert property ((powerMode_q == wdt_pkg::PM_DOWN
    && !extReset) [*2] |-> !oscRun_q)
    else $error("oscillator kept running in deep sleep");

  a_cold_kept : assert property ((sysReset_q && !wrPwrCtl)
    |=> $stable(coldStart_q))
    else $error("cold start flag changed by a warm reset");

endmodule // watchdog_power_reset_ctrl

// file: verification/reset_source.sv
// far-side model: the external source that drives the reset pin level
// assumes it shares core_clk with the block, since that clock stands for the oscillator
`timescale 1ns/1ps

module reset_source (
  input  wire logic core_clk,
  output logic      extReset
);
  initial extReset = 1'b0;

  // ==================================================================
  // pulse the pin high for a number of clocks; short pulses model glitches
  task automatic hold(input int cycles);
    @(posedge core_clk);
    extReset <= 1'b1;
    repeat (cycles) @(posedge core_clk);
    extReset <= 1'b0;
  endtask
endmodule // reset_source

// file: verification/testbench.sv
// self-checking bench for the supervisory block, driven over AXI4-Lite
// assumes a 4-bit watchdog chain so that one time-out is 16 x prescale x 12 clocks
`timescale 1ns/1ps

module testbench;
  // ==================================================================
  // signals
  localparam logic [11:0] PC_A = {wdt_pkg::PWRCTL_INDEX, 2'b00};
  localparam logic [11:0] WD_A = {wdt_pkg::WDCTL_INDEX, 2'b00};
  localparam logic [11:0] NO_A = 12'h040;
  logic               core_clk = 1'b0;
  logic               srst     = 1'b1;
  logic               irqReq   = 1'b0;
  wdt_pkg::axil_req_s axiReq   = '0;
  wdt_pkg::axil_rsp_s axiRsp;
  logic               extReset, sysReset_q, cpuClkRun_q, periphClkRun_q, oscRun_q;
  logic [7:0]         portInit_q, stackInit_q;
  logic [31:0]        rdVal;
  logic [1:0]         resp;
  logic               hit;
  int                 errTotal = 0;
  int                 testsRun = 0;

  always #2.5 core_clk = ~core_clk;

  watchdog_power_reset_ctrl #(.WDT_BITS(4)) uut (
    .core_clk(core_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
    .extReset(extReset), .irqReq(irqReq), .sysReset_q(sysReset_q),
    .cpuClkRun_q(cpuClkRun_q), .periphClkRun_q(periphClkRun_q), .oscRun_q(oscRun_q),
    .portInit_q(portInit_q), .stackInit_q(stackInit_q));

  reset_source rs (.core_clk(core_clk), .extReset(extReset));

  // ==================================================================
  // tasks
  task automatic stop_test();
    if (errTotal == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      errTotal++;
    end
  endtask

  task automatic wrChk(input string name, input logic [11:0] a, input logic [7:0] d,
                       input logic [1:0] expResp);
    int n;
    n = 0;
    @(posedge core_clk);
    axiReq.awaddr  <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= {24'h0, d};
    axiReq.wstrb   <= 4'hf;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 50);
    if (axiRsp.bvalid !== 1'b1) errTotal++;
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    check(name, {30'h0, expResp}, {30'h0, resp});
  endtask

  task automatic rdChk(input string name, input logic [11:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge core_clk);
    axiReq.araddr  <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (axiReq.arvalid && axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 50);
    if (axiRsp.rvalid !== 1'b1) errTotal++;
    rdVal = axiRsp.rdata;
    resp  = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    check(name, exp, rdVal);
  endtask

  // hit goes high if the system reset is seen within lim clocks
  task automatic waitRst(input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && hit !== 1'b1; i++) begin
      @(posedge core_clk);
      if (sysReset_q === 1'b1) hit = 1'b1;
    end
  endtask

  task automatic waitLow();
    for (int i = 0; i < 40 && sysReset_q !== 1'b0; i++) @(posedge core_clk);
    check("reset release", 32'h0, {31'h0, sysReset_q});
  endtask

  task automatic clkChk(input string name, input logic [2:0] exp);
    repeat (2) @(posedge core_clk);
    check(name, {29'h0, exp}, {29'h0, cpuClkRun_q, periphClkRun_q, oscRun_q});
  endtask

  // ==================================================================
  // scenarios
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("portInit", 32'hff, {24'h0, portInit_q});
    check("stackInit", 32'h07, {24'h0, stackInit_q});
    clkChk("clocks at reset", 3'b111);
    rdChk("pwrctl reset", PC_A, 32'h10);
    rdChk("wdctl reset", WD_A, 32'h00);
    // cold start bit written as one so that it is kept
    wrChk("pwrctl flags wr", PC_A, 8'h1c, wdt_pkg::RESP_OKAY);
    rdChk("pwrctl flags", PC_A, 32'h1c);
    wrChk("pwrctl cold wr", PC_A, 8'h10, wdt_pkg::RESP_OKAY);
    rdChk("pwrctl cold kept", PC_A, 32'h10);
    wrChk("pwrctl clear wr", PC_A, 8'h0c, wdt_pkg::RESP_OKAY);
    rdChk("pwrctl cold cleared", PC_A, 32'h0c);
    wrChk("unmapped write", NO_A, 8'h55, wdt_pkg::RESP_DECERR);
    rdChk("unmapped read", NO_A, 32'h0);
    check("unmapped rresp", {30'h0, wdt_pkg::RESP_DECERR}, {30'h0, resp});
    rs.hold(3);
    waitRst(40);
    check("glitch ignored", 32'h0, {31'h0, hit});
    // code 0 expires after 16 x 2 x 12 clocks
    wrChk("wdt start", WD_A, 8'h80, wdt_pkg::RESP_OKAY);
    waitRst(340);
    check("early expiry", 32'h0, {31'h0, hit});
    waitRst(100);
    check("expiry", 32'h1, {31'h0, hit});
    waitLow();
    rdChk("wdctl after expiry", WD_A, 32'h00);
    rdChk("pwrctl after expiry", PC_A, 32'h00);
    // restarts keep it quiet; stopping keeps it quiet
    wrChk("wdt start", WD_A, 8'h80, wdt_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      waitRst(200);
      check("restarted", 32'h0, {31'h0, hit});
      wrChk("restart wr", WD_A, 8'hc0, wdt_pkg::RESP_OKAY);
    end
    repeat (14) @(posedge core_clk);
    rdChk("restart self clear", WD_A, 32'h80);
    wrChk("wdt stop", WD_A, 8'h00, wdt_pkg::RESP_OKAY);
    waitRst(500);
    check("stopped", 32'h0, {31'h0, hit});
    // code 1 doubles the period
    wrChk("wdt code 1", WD_A, 8'h81, wdt_pkg::RESP_OKAY);
    waitRst(700);
    check("code 1 early", 32'h0, {31'h0, hit});
    waitRst(150);
    check("code 1 expiry", 32'h1, {31'h0, hit});
    waitLow();
    // idle pauses the watchdog unless idle-run is set
    wrChk("wdt start", WD_A, 8'h80, wdt_pkg::RESP_OKAY);
    wrChk("doze wr", PC_A, 8'h01, wdt_pkg::RESP_OKAY);
    clkChk("doze clocks", 3'b011);
    waitRst(600);
    check("paused in idle", 32'h0, {31'h0, hit});
    irqReq <= 1'b1;
    clkChk("irq wakes", 3'b111);
    irqReq <= 1'b0;
    wrChk("wdt idle run", WD_A, 8'ha0, wdt_pkg::RESP_OKAY);
    wrChk("doze wr", PC_A, 8'h01, wdt_pkg::RESP_OKAY);
    waitRst(450);
    check("counts in idle", 32'h1, {31'h0, hit});
    waitLow();
    clkChk("reset wakes", 3'b111);
    // deep sleep ignores interrupts, only a pin reset ends it
    wrChk("deep wr", PC_A, 8'h02, wdt_pkg::RESP_OKAY);
    clkChk("deep clocks", 3'b000);
    irqReq <= 1'b1;
    clkChk("irq ignored", 3'b000);
    irqReq <= 1'b0;
    rs.hold(40);
    waitRst(20);
    check("pin reset", 32'h1, {31'h0, hit});
    waitLow();
    clkChk("deep exit", 3'b111);
    rdChk("pwrctl after pin reset", PC_A, 32'h00);
    stop_test();
  end
endmodule // testbench
